// ===== atw_pkg.sv
// constants, types and register map of the two-wire adc host controller
// assumes a 200 MHz clk; shared by atw_host and the bench
`default_nettype none
package atw_pkg;
  localparam int CLK_MHZ        = 200;
  localparam int FS_RATE_KHZ    = 400;
  localparam int HS_RATE_KHZ    = 1700;
  localparam int PHASES_PER_BIT = 3;

  // shortest phase that keeps the line at or below its rate
  function automatic int phase_cycles(input int rate_khz);
    int c;
    c = (CLK_MHZ * 1000 + PHASES_PER_BIT * rate_khz - 1) / (PHASES_PER_BIT * rate_khz);
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [15:0] DIV_FS_RST = 16'(phase_cycles(FS_RATE_KHZ));
  localparam logic [15:0] DIV_HS_RST = 16'(phase_cycles(HS_RATE_KHZ));
  localparam logic [15:0] TMR_ONE    = 16'h0001;

  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DIV_FS = 8'h08;
  localparam logic [7:0] REG_DIV_HS = 8'h0C;
  localparam logic [7:0] REG_ADDR   = 8'h10;
  localparam logic [7:0] REG_SETUP  = 8'h14;

  localparam int CMD_START     = 8;
  localparam int CMD_STOP      = 9;
  localparam int CMD_READ      = 10;
  localparam int CMD_NACK      = 11;
  localparam int CMD_USE_ADDR  = 12;
  localparam int CMD_STOP_ONLY = 13;

  localparam int STS_BUSY = 0;
  localparam int STS_NACK = 1;
  localparam int STS_HS   = 2;
  localparam int STS_HELD = 3;
  localparam int STS_RX   = 8;

  localparam logic [4:0] MCODE_HI   = 5'h01;
  localparam logic [7:0] SETUP_RST  = 8'h82;
  localparam logic [7:0] SETUP_KEEP = 8'hFC;
  localparam logic [6:0] ADDR_RST   = 7'h00;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_START = 4'h2,
    ST_BIT   = 4'h4,
    ST_STOP  = 4'h8
  } atw_fsm_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } atw_line_t;

  typedef struct packed {
    atw_fsm_t    state;
    logic [1:0]  ph;
    logic [15:0] tmr;
    logic [3:0]  bitn;
    logic [7:0]  shift;
    logic        stop_after;
    logic        rd;
    logic        nack_send;
    logic        first_byte;
    logic        bus_held;
    logic        busy;
    logic        nack_seen;
    logic        hs;
    logic [7:0]  rx;
    logic [15:0] div_fs;
    logic [15:0] div_hs;
    logic [6:0]  addr;
    logic [7:0]  setup;
    logic        a_valid;
    logic        a_write;
    logic [7:0]  a_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    atw_line_t   line_o;
    atw_line_t   line_oe;
  } atw_state_t;
endpackage
`default_nettype wire

// ===== atw_pin_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to clk; output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module atw_pin_sync #(
  parameter int             W    = 2,
  parameter logic [W-1:0]   IDLE = '1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } atw_sync_t;

  atw_sync_t sync_reg;
  atw_sync_t sync_next;

  always_comb begin
    sync_next = sync_reg;
    if (ce) begin
      sync_next.s1 = d;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      // per bit: only a stable pair moves the output
      for (int i = 0; i < W; i++) begin
        if (sync_reg.s2[i] == sync_reg.s3[i]) begin
          sync_next.q[i] = sync_reg.s3[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_reg <= {IDLE, IDLE, IDLE, IDLE};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.q;
endmodule
`default_nettype wire

// ===== atw_host.sv
// two-wire bus master for a successive-approximation adc, driven by byte commands over ahb-lite
// assumes pull-ups on scl and sda outside; the oe outputs pull the lines low
// Function
// - one bit per clock cycle; a full transfer takes at least eighteen clocks.
// - data stays steady while clock is high; idle bus leaves both lines high.
// - master opens with data falling, closes with data rising, clock high.
// - repeated start may replace stop and keeps the current speed mode.
// - acknowledge: receiver holds data low across the ninth clock high phase.
// - not-acknowledge: receiver leaves data released through the ninth clock pulse.
// - on a missing acknowledge the master retries later; this core only sets the status nack bit and carries on.
// - address byte lsb: zero is write, one is read.
// - master code 0000 1xxx gets a not-acknowledge, then high-speed mode.
// - after that, master sends repeated start and address for high-speed transfers.
// - write cycle: start, seven address bits, zero bit, then acknowledged data.
// - one or two bytes per write cycle in any order, each acknowledged.
// - master ends a write cycle with stop or repeated start.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module atw_host (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        scl_i,
  output var  logic        scl_o,
  output var  logic        scl_oe,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe
);
  atw_pkg::atw_state_t r;
  atw_pkg::atw_state_t n;
  atw_pkg::atw_line_t  line_f;
  logic                need_high;
  logic                go;
  logic [15:0]         div_cur;
  logic [7:0]          cmd_byte;

  // oe for a data slot: own bits when writing, the ack slot when reading
  function automatic logic drive_oe(input logic rd, input logic ack, input logic msb, input logic nack);
    if (ack) begin
      return rd ? ~nack : 1'b0;
    end
    return rd ? 1'b0 : ~msb;
  endfunction

  atw_pin_sync #(
    .W    (2),
    .IDLE (2'h3)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .d    ({scl_i, sda_i}),
    .q    (line_f)
  );

  always_comb begin
    n         = r;
    div_cur   = r.hs ? r.div_hs : r.div_fs;
    need_high = (r.ph == 2'h1) && (r.state != atw_pkg::ST_IDLE);
    // clock phase only counts once the line is really high: the device may stretch it
    go        = (r.state != atw_pkg::ST_IDLE) && (r.tmr == '0) && (!need_high || line_f.scl);
    cmd_byte  = hwdata[atw_pkg::CMD_USE_ADDR] ? {r.addr, hwdata[0]} : hwdata[7:0];
    if (ce) begin
      if (r.state != atw_pkg::ST_IDLE) begin
        if ((need_high && !line_f.scl) || r.tmr == '0) begin
          n.tmr = div_cur - atw_pkg::TMR_ONE;
        end else begin
          n.tmr = r.tmr - atw_pkg::TMR_ONE;
        end
      end

      // ahb data phase: register writes
      if (r.a_valid && r.a_write) begin
        case (r.a_addr)
          atw_pkg::REG_CMD: begin
            if (!r.busy) begin
              n.shift      = cmd_byte;
              n.stop_after = hwdata[atw_pkg::CMD_STOP];
              n.rd         = hwdata[atw_pkg::CMD_READ];
              n.nack_send  = hwdata[atw_pkg::CMD_NACK];
              n.bitn       = '0;
              n.ph         = 2'h0;
              n.tmr        = div_cur - atw_pkg::TMR_ONE;
              if (hwdata[atw_pkg::CMD_START]) begin
                // start or repeated start; a held bus keeps its speed mode
                n.state        = atw_pkg::ST_START;
                n.busy         = 1'b1;
                n.line_oe.sda  = 1'b0;
              end else if (r.bus_held && hwdata[atw_pkg::CMD_STOP_ONLY]) begin
                n.state        = atw_pkg::ST_STOP;
                n.busy         = 1'b1;
                n.line_oe.sda  = 1'b1;
              end else if (r.bus_held) begin
                // further byte of a cycle; software keeps one or two per write
                n.state        = atw_pkg::ST_BIT;
                n.busy         = 1'b1;
                n.line_oe.sda  = drive_oe(hwdata[atw_pkg::CMD_READ], 1'b0, cmd_byte[7],
                                          hwdata[atw_pkg::CMD_NACK]);
              end
            end
          end
          atw_pkg::REG_DIV_FS: n.div_fs = hwdata[15:0];
          atw_pkg::REG_DIV_HS: n.div_hs = hwdata[15:0];
          atw_pkg::REG_ADDR:   n.addr   = hwdata[6:0];
          default: ;
        endcase
      end

      // ahb address phase; read data is fetched here so it stands for the data phase
      n.a_valid = hsel && hready && htrans[1] && (hsize == atw_pkg::HSIZE_WORD);
      n.a_write = hwrite;
      n.a_addr  = haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        n.hrdata = '0;
        case (haddr[7:0])
          atw_pkg::REG_STATUS: begin
            n.hrdata[atw_pkg::STS_BUSY]              = r.busy;
            n.hrdata[atw_pkg::STS_NACK]              = r.nack_seen;
            n.hrdata[atw_pkg::STS_HS]                = r.hs;
            n.hrdata[atw_pkg::STS_HELD]              = r.bus_held;
            n.hrdata[atw_pkg::STS_RX +: 8]           = r.rx;
          end
          atw_pkg::REG_DIV_FS: n.hrdata[15:0] = r.div_fs;
          atw_pkg::REG_DIV_HS: n.hrdata[15:0] = r.div_hs;
          atw_pkg::REG_ADDR:   n.hrdata[6:0]  = r.addr;
          atw_pkg::REG_SETUP:  n.hrdata[7:0]  = r.setup;
          default: ;
        endcase
      end

      // line sequencer: three equal phases per bit (set data, clock high, hold)
      if (go) begin
        case (r.state)
          atw_pkg::ST_START: begin
            case (r.ph)
              2'h0: begin
                n.ph         = 2'h1;
                n.line_oe.scl = 1'b0;
              end
              2'h1: begin
                // data falls with clock high
                n.ph          = 2'h2;
                n.line_oe.sda = 1'b1;
              end
              2'h2: begin
                n.ph          = 2'h3;
                n.line_oe.scl = 1'b1;
              end
              default: begin
                n.state       = atw_pkg::ST_BIT;
                n.ph          = 2'h0;
                n.first_byte  = 1'b1;
                n.line_oe.sda = drive_oe(r.rd, 1'b0, r.shift[7], r.nack_send);
              end
            endcase
          end
          atw_pkg::ST_BIT: begin
            case (r.ph)
              2'h0: begin
                n.ph          = 2'h1;
                n.line_oe.scl = 1'b0;
              end
              2'h1: begin
                // sample at the end of the high phase, one bit per clock
                n.ph          = 2'h2;
                n.line_oe.scl = 1'b1;
                if (r.bitn != atw_pkg::ACK_SLOT) begin
                  n.shift = {r.shift[6:0], line_f.sda};
                end else begin
                  // released line read high is a not-acknowledge
                  n.nack_seen  = line_f.sda;
                  n.first_byte = 1'b0;
                  if (r.rd) begin
                    n.rx = r.shift;
                  end else if (r.first_byte && r.shift[7:3] == atw_pkg::MCODE_HI && line_f.sda) begin
                    n.hs = 1'b1;
                  end else if (!r.first_byte && r.shift[7] && !line_f.sda) begin
                    // shadow of the last accepted setup byte; bit 1 acts on configuration only
                    n.setup = (r.shift & atw_pkg::SETUP_KEEP) | (atw_pkg::SETUP_RST & ~atw_pkg::SETUP_KEEP);
                  end
                end
              end
              default: begin
                if (r.bitn == atw_pkg::ACK_SLOT) begin
                  n.ph = 2'h0;
                  if (r.stop_after) begin
                    n.state       = atw_pkg::ST_STOP;
                    n.line_oe.sda = 1'b1;
                  end else begin
                    // clock stays low so the bus remains ours
                    n.state       = atw_pkg::ST_IDLE;
                    n.busy        = 1'b0;
                    n.bus_held    = 1'b1;
                    n.line_oe.sda = 1'b0;
                  end
                end else begin
                  n.ph          = 2'h0;
                  n.bitn        = r.bitn + 4'h1;
                  n.line_oe.sda = drive_oe(r.rd, (r.bitn + 4'h1) == atw_pkg::ACK_SLOT,
                                           r.shift[7], r.nack_send);
                end
              end
            endcase
          end
          atw_pkg::ST_STOP: begin
            case (r.ph)
              2'h0: begin
                n.ph          = 2'h1;
                n.line_oe.scl = 1'b0;
              end
              2'h1: begin
                // data rises with clock high: bus returns to idle
                n.ph          = 2'h2;
                n.line_oe.sda = 1'b0;
              end
              default: begin
                n.state    = atw_pkg::ST_IDLE;
                n.ph       = 2'h0;
                n.busy     = 1'b0;
                n.bus_held = 1'b0;
                n.hs       = 1'b0;
              end
            endcase
          end
          default: begin
            n.state = atw_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r           <= '0;
      r.state     <= atw_pkg::ST_IDLE;
      r.div_fs    <= atw_pkg::DIV_FS_RST;
      r.div_hs    <= atw_pkg::DIV_HS_RST;
      r.addr      <= atw_pkg::ADDR_RST;
      r.setup     <= atw_pkg::SETUP_RST;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.hreadyout;
  assign hresp     = r.hresp;
  assign hrdata    = r.hrdata;
  assign scl_o     = r.line_o.scl;
  assign scl_oe    = r.line_oe.scl;
  assign sda_o     = r.line_o.sda;
  assign sda_oe    = r.line_oe.sda;
endmodule
`default_nettype wire

// ===== atw_props.sv
// checker on atw_host ports: bus answer, open-drain lines, start/stop shape, phase lengths
// assumes the bench sets both dividers to at least 4 before any traffic
`timescale 1ns/1ps
`default_nettype none
module atw_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd_hole;
    hsel && htrans[1] && !hwrite && hreadyout && haddr[7:0] == 8'h18;
  endsequence
  sequence s_low_phase;
    scl_oe [*4];
  endsequence
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_hole_zero: assert property (s_rd_hole |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_open_drain: assert property (!scl_o && !sda_o) else $error("line driven high");
  a_start_form: assert property ($rose(sda_oe) && !scl_oe |-> scl_i && $past(sda_i) && !sda_i) else $error("bad start");
  a_stop_form: assert property ($fell(sda_oe) && !scl_oe |-> scl_i && !$past(sda_i) && sda_i) else $error("bad stop");
  a_low_len: assert property ($rose(scl_oe) |-> s_low_phase) else $error("clock low too short");
  a_high_len: assert property ($fell(scl_oe) |-> !scl_oe [*4]) else $error("clock high too short");
endmodule
bind atw_host atw_props u_props (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hreadyout, .hresp,
  .hrdata, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);
`default_nettype wire

// ===== atw_adc_model.sv
// behavioural adc slave: address match, acks, speed mode, setup and config bytes
// assumes the bench resolves both lines with pull-ups; this model only pulls low
`timescale 1ns/1ps
`default_nettype none
module atw_adc_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
  parameter logic [7:0] CFG_DEF  = 8'h01
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       stretch_en,
  output var  logic       scl_pull,
  output var  logic       sda_pull,
  output var  logic       hs_q,
  output var  logic [7:0] setup_q,
  output var  logic [7:0] config_q
);
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       first;
  logic       sel;
  logic       hs_pend;
  initial begin
    {scl_pull, sda_pull, hs_q, first, sel, hs_pend} = '0;
    cnt = 4'h0;
    setup_q = 8'h00;
    config_q = CFG_DEF;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 4'h0;
    first = 1'b1;
    sel = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    sel = 1'b0;
    hs_q = 1'b0;
  end
  always @(posedge scl) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda};
    if (cnt < 4'h9) cnt = cnt + 4'h1;
  end
  always @(negedge scl) begin
    if (cnt == 4'h8) begin
      if (first) begin
        hs_pend = sh[7:3] == 5'h01;
        sel = sh[7:1] == DEV_ADDR && !sh[0]; // reads not modelled
      end else if (sel && sh[7]) begin
        setup_q = {1'b0, sh[6:2], 2'b00};
        if (!sh[1]) config_q = CFG_DEF;
      end else if (sel) config_q = sh;
      sda_pull = sel;
    end else if (cnt == 4'h9) begin
      sda_pull = 1'b0;
      cnt = 4'h0;
      first = 1'b0;
      if (hs_pend) hs_q = 1'b1;
      hs_pend = 1'b0;
      if (stretch_en && !setup_q[3]) begin // internal clock holds scl while converting
        scl_pull = 1'b1;
        #2000;
        scl_pull = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== atw_tb.sv
// self-checking bench: atw_host against the adc model over ahb-lite
// assumes pull-ups on both lines, resolved here from all enables
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [6:0] DEV = 7'h2A;
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        scl_oe;
  logic        sda_oe;
  logic        m_scl;
  logic        m_sda;
  logic        stretch_en;
  logic        hs_q;
  logic [7:0]  setup_q;
  logic [7:0]  config_q;
  logic [31:0] q;
  wire logic   scl = ~(scl_oe | m_scl);
  wire logic   sda = ~(sda_oe | m_sda);
  int          miscompares;
  int          num_checks;
  atw_host u_dut (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  atw_adc_model #(.DEV_ADDR(DEV)) u_adc (.scl(scl), .sda(sda), .stretch_en(stretch_en), .scl_pull(m_scl),
    .sda_pull(m_sda), .hs_q(hs_q), .setup_q(setup_q), .config_q(config_q));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results;
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic waitrdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) begin
      miscompares++;
      results();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= atw_pkg::HSIZE_WORD;
    waitrdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy();
    q = hrdata;
  endtask
  // poll busy; a clock held low would otherwise hang here
  task automatic cmd(input logic [31:0] v);
    int n;
    bus(1'b1, atw_pkg::REG_CMD, v);
    n = 0;
    do begin
      bus(1'b0, atw_pkg::REG_STATUS, 32'h0);
      n++;
    end while (q[atw_pkg::STS_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      miscompares++;
      results();
    end
  endtask
  task automatic st(input logic [3:0] e);
    bus(1'b0, atw_pkg::REG_STATUS, 32'h0);
    chk("status", {28'h0, e}, q & 32'hF);
  endtask
  task automatic t_regs;
    logic [7:0] a[6] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h04, 8'h18};
    logic [31:0] e[6] = '{32'hA7, 32'h28, 32'h0, 32'h82, 32'h0, 32'h0};
    bus(1'b1, 8'h18, 32'hFFFF);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk("reset value", e[i], q);
    end
    bus(1'b1, atw_pkg::REG_DIV_FS, 32'h4);
    bus(1'b1, atw_pkg::REG_DIV_HS, 32'h4);
    bus(1'b1, atw_pkg::REG_ADDR, {25'h0, DEV});
    bus(1'b0, atw_pkg::REG_ADDR, 32'h0);
    chk("addr", {25'h0, DEV}, q);
    // a write while ce is low must be lost
    ce <= 1'b0;
    bus(1'b1, atw_pkg::REG_ADDR, 32'h0);
    ce <= 1'b1;
    bus(1'b0, atw_pkg::REG_ADDR, 32'h0);
    chk("frozen addr", {25'h0, DEV}, q);
  endtask
  task automatic t_write;
    cmd(32'h1100);
    st(4'h8);
    cmd(32'h000A);
    st(4'h8);
    cmd(32'h02FF);
    st(4'h0);
    chk("setup", 32'h7C, {24'h0, setup_q});
    chk("config", 32'h0A, {24'h0, config_q});
    bus(1'b0, atw_pkg::REG_SETUP, 32'h0);
    chk("shadow", 32'hFE, q);
    cmd(32'h1100);
    cmd(32'h0280);
    chk("setup", 32'h00, {24'h0, setup_q});
    chk("config", 32'h01, {24'h0, config_q});
  endtask
  task automatic t_other;
    bus(1'b1, atw_pkg::REG_ADDR, {25'h0, DEV ^ 7'h01});
    cmd(32'h1100);
    st(4'hA);
    // nobody drives the line: a read byte sees all ones, own not-acknowledge
    cmd(32'h0C00);
    bus(1'b0, atw_pkg::REG_STATUS, 32'h0);
    chk("released read", 32'hFF0A, q);
    cmd(32'h2000);
    st(4'h2);
    bus(1'b1, atw_pkg::REG_ADDR, {25'h0, DEV});
    cmd(32'h1100);
    st(4'h8);
    cmd(32'h2000);
  endtask
  task automatic t_hs;
    cmd(32'h010D);
    st(4'hE);
    chk("hs", 32'h1, {31'h0, hs_q});
    cmd(32'h1100);
    st(4'hC);
    cmd(32'h2000);
    st(4'h0);
    chk("hs", 32'h0, {31'h0, hs_q});
  endtask
  task automatic t_stretch;
    time t0;
    stretch_en <= 1'b1;
    cmd(32'h1100);
    t0 = $time;
    cmd(32'h0233);
    chk("stretch", 32'h1, {31'h0, ($time - t0) > 1500});
    chk("config", 32'h33, {24'h0, config_q});
    stretch_en <= 1'b0;
  endtask
  initial begin
    {nrst, hsel, hwrite, stretch_en} = '0;
    ce = 1'b1;
    {haddr, hwdata, htrans, hsize} = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_write();
    t_other();
    t_hs();
    t_stretch();
    results();
  end
endmodule
`default_nettype wire
